// ==== design/dbd_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the dimming and fault block.
`ifndef DBD_CFG_SVH
`define DBD_CFG_SVH

`define DBD_ADDR_CTRL1 8'h04
`define DBD_ADDR_CTRL3 8'h0c
`define DBD_ADDR_STAT1 8'h14
`define DBD_ADDR_STAT2 8'h18
`define DBD_ADDR_GSB 8'h1c
`define DBD_ADDR_MODE 8'h20

`define DBD_DUTY1_MSB 23
`define DBD_DUTY1_LSB 14
`define DBD_DUTY2_MSB 13
`define DBD_DUTY2_LSB 4
`define DBD_MAP1_MSB 15
`define DBD_MAP1_LSB 14
`define DBD_MAP2_MSB 13
`define DBD_MAP2_LSB 12

`define DBD_S1_SHT2 7
`define DBD_S1_SHT1 6
`define DBD_S1_CHANNEL1_OVERHEAT_FLAG 5
`define DBD_S1_TW12 4
`define DBD_S1_TW11 3
`define DBD_S1_MIN2 2
`define DBD_S1_MIN1 1
`define DBD_S2_CHANNEL2_OVERHEAT_FLAG 23
`define DBD_S2_TW22 22
`define DBD_S2_TW21 21
`define DBD_S2_MAX2 20
`define DBD_S2_MAX1 19
`define DBD_S2_CLKF 0
`define DBD_G_FE2 28
`define DBD_G_FE1 27
`define DBD_G_DE 26
`define DBD_G_GW 25
`define DBD_G_FS 24

`define DBD_CTRL1_RST 32'h0000_0000
`define DBD_CTRL3_RST 32'h0000_c000

`define DBD_CLK_NS 20
`define DBD_DIN_FT_NS 32000
`define DBD_DIN_FT_CYC ((`DBD_DIN_FT_NS + `DBD_CLK_NS - 1) / `DBD_CLK_NS)

`endif

// ==== design/dbd_pkg.sv ====
// Types shared by the dimming and fault block.
package dbd_pkg;

    typedef enum logic [1:0] {
        DBD_SRC_OFF,
        DBD_SRC_PWM,
        DBD_SRC_ON,
        DBD_SRC_DIN
    } dbd_src_t;

endpackage

// ==== design/dbd_channel_fault.sv ====
// Fault detection and latching for one buck channel.
`timescale 1ns/100ps
`default_nettype none

module dbd_channel_fault #(
    parameter int FAIL_N = 8,
    parameter int GOOD_N = 16,
    parameter int TMAX_OFF = 64
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic active_i,
    input wire logic restart_i,
    input wire logic startup_i,
    input wire logic cycle_end_i,
    input wire logic peak_early_i,
    input wire logic ton_long_i,
    input wire logic ton_at_max_i,
    input wire logic vled_low_i,
    input wire logic tsd_hot_i,
    input wire logic tsd_cool_i,
    input wire logic clr_ovt_i,
    input wire logic clr_min_i,
    input wire logic clr_sht_i,
    input wire logic clr_max_i,
    output logic ovt_o,
    output logic min_o,
    output logic sht_o,
    output logic max_o,
    output logic off_o
);

    logic [7:0] fail_cnt_r;
    logic [7:0] good_cnt_r;
    logic prev_max_r;
    logic [15:0] off_cnt_r;
    logic fail_hit;
    logic max_hit;
    logic restart_ok;

    initial begin
        if (FAIL_N < 1 || FAIL_N > 255 || GOOD_N < 1 || GOOD_N > 255) begin
            $error("dbd_channel_fault: counts out of range");
        end
        if (TMAX_OFF < 1 || TMAX_OFF > 65535) begin
            $error("dbd_channel_fault: off interval out of range");
        end
    end

    // Counting stops in startup; a fail reaching the count validates the fault.
    assign fail_hit = cycle_end_i && peak_early_i && !startup_i
                      && (fail_cnt_r == 8'(FAIL_N - 1));
    assign max_hit = cycle_end_i && ton_at_max_i && prev_max_r;
    assign restart_ok = restart_i && !active_i;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fail_cnt_r <= 8'h00;
            good_cnt_r <= 8'h00;
        end else if (cycle_end_i && !startup_i) begin
            if (peak_early_i) begin
                good_cnt_r <= 8'h00;
                fail_cnt_r <= fail_hit ? 8'h00 : fail_cnt_r + 8'h01;
            end else if (ton_long_i) begin
                if (good_cnt_r == 8'(GOOD_N - 1)) begin
                    good_cnt_r <= 8'h00;
                    fail_cnt_r <= 8'h00;
                end else begin
                    good_cnt_r <= good_cnt_r + 8'h01;
                end
            end else begin
                good_cnt_r <= 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_max_r <= 1'b0;
        end else if (cycle_end_i) begin
            prev_max_r <= ton_at_max_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            off_cnt_r <= 16'h0000;
        end else if (max_hit) begin
            off_cnt_r <= 16'(TMAX_OFF);
        end else if (off_cnt_r != 16'h0000) begin
            off_cnt_r <= off_cnt_r - 16'h0001;
        end
    end

    // Each flag: a new event wins over a clear in the same cycle.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ovt_o <= 1'b0;
        end else if (tsd_hot_i) begin
            ovt_o <= 1'b1;
        end else if (tsd_cool_i && ((active_i && clr_ovt_i) || restart_ok)) begin
            ovt_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            min_o <= 1'b0;
            sht_o <= 1'b0;
            max_o <= 1'b0;
        end else begin
            if (fail_hit && !vled_low_i) begin
                min_o <= 1'b1;
            end else if ((active_i && clr_min_i) || restart_ok) begin
                min_o <= 1'b0;
            end
            if (fail_hit && vled_low_i) begin
                sht_o <= 1'b1;
            end else if ((active_i && clr_sht_i) || restart_ok) begin
                sht_o <= 1'b0;
            end
            if (max_hit) begin
                max_o <= 1'b1;
            end else if ((active_i && clr_max_i) || restart_ok) begin
                max_o <= 1'b0;
            end
        end
    end

    // In Active mode max on-time only blanks for the off interval; in Limp Home it latches.
    assign off_o = ovt_o || min_o || sht_o || (off_cnt_r != 16'h0000)
                   || (!active_i && max_o);

endmodule

`default_nettype wire

// ==== design/dbd_dimming_ctrl.sv ====
// Two-channel dimming source selection, PWM generator, clock fallback and fault control.
`timescale 1ns/100ps
`default_nettype none
`include "dbd_cfg.svh"

module dbd_dimming_ctrl
    import dbd_pkg::*;
#(
    parameter int FAIL_N = 8,
    parameter int GOOD_N = 16,
    parameter int TMAX_OFF = 64,
    parameter int RESTART_CYC = 500000,
    parameter int CLK_TIMEOUT = 1000,
    parameter int FALLBACK_DIV = 50
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic dim_clk_i,
    input wire logic din_i,
    input wire logic vs_uv_i,
    input wire logic [3:0] tw_i,
    input wire logic [1:0] tsd_hot_i,
    input wire logic [1:0] tsd_cool_i,
    input wire logic [1:0] startup_i,
    input wire logic [1:0] cycle_end_i,
    input wire logic [1:0] peak_early_i,
    input wire logic [1:0] ton_long_i,
    input wire logic [1:0] ton_at_max_i,
    input wire logic [1:0] vled_low_i,
    output logic [1:0] buck_en_o,
    output logic fallback_en_o
);

    localparam logic [10:0] DIN_FT = 11'(`DBD_DIN_FT_CYC);

    initial begin
        if (RESTART_CYC < 2 || CLK_TIMEOUT < 2 || CLK_TIMEOUT > 65535) begin
            $error("dbd_dimming_ctrl: timing parameter out of range");
        end
        if (FALLBACK_DIV < 1 || FALLBACK_DIV > 65535) begin
            $error("dbd_dimming_ctrl: fallback divider out of range");
        end
    end

    // =====================================================================
    // Register bus
    // =====================================================================
    logic [31:0] first_control_word_r;
    logic [31:0] third_control_word_r;
    logic active_r;
    logic [31:0] rdata_nxt;
    logic [31:0] first_status_word;
    logic [31:0] second_status_word;
    logic [31:0] gsb;
    logic setup;
    logic access;
    logic mapped;
    logic [1:0] ovt;
    logic [1:0] minf;
    logic [1:0] sht;
    logic [1:0] maxf;
    logic [1:0] off;
    logic dimming_clock_fail_flag_r;
    logic clr_s1;
    logic clr_s2;

    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    assign mapped = (paddr_i == `DBD_ADDR_CTRL1) || (paddr_i == `DBD_ADDR_CTRL3)
                    || (paddr_i == `DBD_ADDR_STAT1) || (paddr_i == `DBD_ADDR_STAT2)
                    || (paddr_i == `DBD_ADDR_GSB) || (paddr_i == `DBD_ADDR_MODE);
    assign pready_o = 1'b1;
    assign pslverr_o = access && !mapped;

    always_comb begin
        first_status_word = 32'h0000_0000;
        first_status_word[`DBD_S1_SHT2] = sht[1];
        first_status_word[`DBD_S1_SHT1] = sht[0];
        first_status_word[`DBD_S1_CHANNEL1_OVERHEAT_FLAG] = ovt[0];
        first_status_word[`DBD_S1_TW12] = tw_i[1];
        first_status_word[`DBD_S1_TW11] = tw_i[0];
        first_status_word[`DBD_S1_MIN2] = minf[1];
        first_status_word[`DBD_S1_MIN1] = minf[0];
        second_status_word = 32'h0000_0000;
        second_status_word[`DBD_S2_CHANNEL2_OVERHEAT_FLAG] = ovt[1];
        second_status_word[`DBD_S2_TW22] = tw_i[3];
        second_status_word[`DBD_S2_TW21] = tw_i[2];
        second_status_word[`DBD_S2_MAX2] = maxf[1];
        second_status_word[`DBD_S2_MAX1] = maxf[0];
        second_status_word[`DBD_S2_CLKF] = dimming_clock_fail_flag_r;
        gsb = 32'h0000_0000;
        gsb[`DBD_G_FE2] = |maxf;
        gsb[`DBD_G_FE1] = vs_uv_i || (|ovt) || (|sht) || (|minf);
        gsb[`DBD_G_DE] = dimming_clock_fail_flag_r;
        gsb[`DBD_G_GW] = |tw_i;
        gsb[`DBD_G_FS] = !active_r;
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (paddr_i)
            `DBD_ADDR_CTRL1: rdata_nxt = first_control_word_r;
            `DBD_ADDR_CTRL3: rdata_nxt = third_control_word_r;
            `DBD_ADDR_STAT1: rdata_nxt = first_status_word | gsb;
            `DBD_ADDR_STAT2: rdata_nxt = second_status_word | gsb;
            `DBD_ADDR_GSB: rdata_nxt = gsb;
            `DBD_ADDR_MODE: rdata_nxt = {31'h0000_0000, active_r};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Read data is captured in setup so the clear acts only on bits the host has seen.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup) begin
            prdata_o <= rdata_nxt;
        end
    end

    assign clr_s1 = access && !pwrite_i && (paddr_i == `DBD_ADDR_STAT1);
    assign clr_s2 = access && !pwrite_i && (paddr_i == `DBD_ADDR_STAT2);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            first_control_word_r <= `DBD_CTRL1_RST;
            third_control_word_r <= `DBD_CTRL3_RST;
            active_r <= 1'b0;
        end else if (access && pwrite_i) begin
            if (paddr_i == `DBD_ADDR_CTRL1) begin
                first_control_word_r <= pwdata_i;
            end
            if (paddr_i == `DBD_ADDR_CTRL3) begin
                third_control_word_r <= pwdata_i;
            end
            if (paddr_i == `DBD_ADDR_MODE) begin
                active_r <= pwdata_i[0];
            end
        end
    end

    // =====================================================================
    // Dimming reference clock and fallback
    // =====================================================================
    logic dim_prev_r;
    logic dim_edge;
    logic [15:0] idle_cnt_r;
    logic clk_lost;
    logic [15:0] fb_cnt_r;
    logic fb_tick;
    logic pwm_tick;
    logic [9:0] pwm_cnt_r;

    assign dim_edge = dim_clk_i && !dim_prev_r;
    assign clk_lost = idle_cnt_r == 16'(CLK_TIMEOUT - 1);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dim_prev_r <= 1'b0;
            idle_cnt_r <= 16'h0000;
        end else begin
            dim_prev_r <= dim_clk_i;
            if (dim_edge) begin
                idle_cnt_r <= 16'h0000;
            end else if (!clk_lost) begin
                idle_cnt_r <= idle_cnt_r + 16'h0001;
            end
        end
    end

    // Loss wins over a clear; the clear also needs the reference running again.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dimming_clock_fail_flag_r <= 1'b0;
        end else if (clk_lost) begin
            dimming_clock_fail_flag_r <= 1'b1;
        end else if (clr_s2 && prdata_o[`DBD_S2_CLKF]) begin
            dimming_clock_fail_flag_r <= 1'b0;
        end
    end

    assign fallback_en_o = dimming_clock_fail_flag_r;
    assign fb_tick = fb_cnt_r == 16'(FALLBACK_DIV - 1);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fb_cnt_r <= 16'h0000;
        end else if (!dimming_clock_fail_flag_r || fb_tick) begin
            fb_cnt_r <= 16'h0000;
        end else begin
            fb_cnt_r <= fb_cnt_r + 16'h0001;
        end
    end

    assign pwm_tick = dimming_clock_fail_flag_r ? fb_tick : dim_edge;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwm_cnt_r <= 10'h000;
        end else if (pwm_tick) begin
            pwm_cnt_r <= pwm_cnt_r + 10'h001;
        end
    end

    // =====================================================================
    // Input pin filter and auto-restart timer
    // =====================================================================
    logic din_f_r;
    logic [10:0] din_cnt_r;
    logic [31:0] rs_cnt_r;
    logic restart;

    // Only rising edges are delayed; a falling edge passes at once.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            din_cnt_r <= 11'h000;
            din_f_r <= 1'b0;
        end else if (!din_i) begin
            din_cnt_r <= 11'h000;
            din_f_r <= 1'b0;
        end else if (din_cnt_r == DIN_FT - 11'h001) begin
            din_f_r <= 1'b1;
        end else begin
            din_cnt_r <= din_cnt_r + 11'h001;
        end
    end

    assign restart = rs_cnt_r == 32'(RESTART_CYC - 1);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rs_cnt_r <= 32'h0000_0000;
        end else if (restart || active_r) begin
            rs_cnt_r <= 32'h0000_0000;
        end else begin
            rs_cnt_r <= rs_cnt_r + 32'h0000_0001;
        end
    end

    // =====================================================================
    // Channels
    // =====================================================================
    logic [1:0][1:0] map;
    logic [1:0][9:0] duty;
    logic [1:0] buck_nxt;
    logic [1:0] clr_ovt;

    assign map[0] = active_r ? third_control_word_r[`DBD_MAP1_MSB:`DBD_MAP1_LSB]
                             : 2'(`DBD_CTRL3_RST >> `DBD_MAP1_LSB);
    assign map[1] = active_r ? third_control_word_r[`DBD_MAP2_MSB:`DBD_MAP2_LSB]
                             : 2'(`DBD_CTRL3_RST >> `DBD_MAP2_LSB);
    assign duty[0] = first_control_word_r[`DBD_DUTY1_MSB:`DBD_DUTY1_LSB];
    assign duty[1] = first_control_word_r[`DBD_DUTY2_MSB:`DBD_DUTY2_LSB];
    assign clr_ovt[0] = clr_s1 && prdata_o[`DBD_S1_CHANNEL1_OVERHEAT_FLAG];
    assign clr_ovt[1] = clr_s2 && prdata_o[`DBD_S2_CHANNEL2_OVERHEAT_FLAG];

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic src_on;

        dbd_channel_fault #(
            .FAIL_N(FAIL_N),
            .GOOD_N(GOOD_N),
            .TMAX_OFF(TMAX_OFF)
        ) u_fault (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .active_i(active_r),
            .restart_i(restart),
            .startup_i(startup_i[c]),
            .cycle_end_i(cycle_end_i[c]),
            .peak_early_i(peak_early_i[c]),
            .ton_long_i(ton_long_i[c]),
            .ton_at_max_i(ton_at_max_i[c]),
            .vled_low_i(vled_low_i[c]),
            .tsd_hot_i(tsd_hot_i[c]),
            .tsd_cool_i(tsd_cool_i[c]),
            .clr_ovt_i(clr_ovt[c]),
            .clr_min_i(clr_s1 && prdata_o[`DBD_S1_MIN1 + c]),
            .clr_sht_i(clr_s1 && prdata_o[`DBD_S1_SHT1 + c]),
            .clr_max_i(clr_s2 && prdata_o[`DBD_S2_MAX1 + c]),
            .ovt_o(ovt[c]),
            .min_o(minf[c]),
            .sht_o(sht[c]),
            .max_o(maxf[c]),
            .off_o(off[c])
        );

        always_comb begin
            unique case (dbd_src_t'(map[c]))
                DBD_SRC_OFF: src_on = 1'b0;
                DBD_SRC_PWM: src_on = pwm_cnt_r < duty[c];
                DBD_SRC_ON: src_on = 1'b1;
                DBD_SRC_DIN: src_on = din_f_r;
            endcase
        end

        assign buck_nxt[c] = src_on && !off[c] && !vs_uv_i;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buck_en_o <= 2'b00;
        end else begin
            buck_en_o <= buck_nxt;
        end
    end

    // =====================================================================
    // Checks
    // =====================================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    chk_uv_all_off: assert property (vs_uv_i |=> buck_en_o == 2'b00)
        else $error("undervoltage did not switch channels off");
    chk_limp_ch2_off: assert property (!active_r |=> !buck_en_o[1])
        else $error("channel 2 running in limp home");
    chk_ovt_off: assert property (ovt[0] |=> !buck_en_o[0])
        else $error("overheated channel 1 still driven");
    chk_ovt_hold: assert property (ovt[0] && !tsd_cool_i[0] |=> ovt[0])
        else $error("overheat flag cleared while hot");
    chk_gw_follow: assert property (gsb[`DBD_G_GW]
                                    == ((|first_status_word[`DBD_S1_TW12:`DBD_S1_TW11])
                                        || (|second_status_word[`DBD_S2_TW22:`DBD_S2_TW21])))
        else $error("global warning mismatch");
    chk_fb_select: assert property (clk_lost |=> fallback_en_o ##0 dimming_clock_fail_flag_r)
        else $error("fallback not engaged on clock loss");
    chk_fail_stick: assert property (dimming_clock_fail_flag_r && !clr_s2
                                     |=> dimming_clock_fail_flag_r)
        else $error("clock fail flag dropped without clear");
    chk_pwm_zero: assert property (active_r && map[0] == 2'b01 && duty[0] == 10'h000
                                   |=> !buck_en_o[0])
        else $error("zero duty still drives channel 1");
    chk_din_delay: assert property ($rose(din_f_r) |-> $past(din_i, 2) && din_i)
        else $error("filtered input rose without held pin");
    chk_max_flag: assert property (maxf[0] && active_r && !clr_s2 |=> maxf[0])
        else $error("max on-time flag dropped without clear");
    chk_wrap_period: assert property (pwm_cnt_r == 10'h3ff && pwm_tick
                                      |=> pwm_cnt_r == 10'h000)
        else $error("dimming period not 1024 ticks");

    cov_fallback: cover property (clk_lost ##[1:100] clr_s2);
    cov_restart: cover property (!active_r && restart && (|sht));
    cov_pwm_on: cover property (active_r && map[1] == 2'b01 && buck_en_o[1]);

endmodule

`default_nettype wire

// ==== bench/dbd_host_model.sv ====
// Host model that drives the register bus of the dimming and fault block.
`timescale 1ns/100ps
`default_nettype none

module dbd_host_model (
    input wire logic clk_i,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o
);
    // ==========================================
    // Bus transfer
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
    end

    // Ends one idle edge after the answer, so calls may follow each other directly.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err, output logic hung);
        hung = 1'b1;
        psel_o <= 1'b1;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        for (int n = 0; n < 16 && hung; n++) begin
            @(posedge clk_i);
            if (pready_i === 1'b1) begin
                hung = 1'b0;
            end
        end
        q = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

// ==== bench/dual_buck_dimming_and_fault_control_test.sv ====
// Self-checking bench for the dimming and fault block.
`timescale 1ns/100ps
`default_nettype none
`include "dbd_cfg.svh"

module dual_buck_dimming_and_fault_control_test import dbd_pkg::*;;
    // ==========================================
    // Signals and instances
    localparam int TOFF = 8;
    localparam logic [7:0] S1 = `DBD_ADDR_STAT1;
    localparam logic [7:0] S2 = `DBD_ADDR_STAT2;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, fallback_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] buck_en;
    logic dim_run = 1'b1;
    logic dim_clk = 1'b0;
    logic din = 1'b0;
    logic vs_uv = 1'b0;
    logic [3:0] tw = 4'h0;
    logic [1:0] hot = 2'h0;
    logic [1:0] cool = 2'h3;
    logic [1:0] cend = 2'h0;
    logic [1:0] atmax = 2'h0;
    logic [1:0] stup = 2'h0, early = 2'h0, tlong = 2'h0, vlow = 2'h0;
    int failures = 0;
    int n_compared = 0;

    dbd_host_model u_host (.clk_i(clk_i), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata));

    dbd_dimming_ctrl #(.FAIL_N(2), .GOOD_N(3), .TMAX_OFF(TOFF), .RESTART_CYC(50),
        .CLK_TIMEOUT(20), .FALLBACK_DIV(2)) DUT (.clk_i(clk_i), .rstn_i(rstn_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .dim_clk_i(dim_clk), .din_i(din), .vs_uv_i(vs_uv), .tw_i(tw), .tsd_hot_i(hot),
        .tsd_cool_i(cool), .startup_i(stup), .cycle_end_i(cend), .peak_early_i(early),
        .ton_long_i(tlong), .ton_at_max_i(atmax), .vled_low_i(vlow),
        .buck_en_o(buck_en), .fallback_en_o(fallback_en));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        dim_clk <= dim_run & ~dim_clk;
    end

    // ==========================================
    // Shared tasks
    task automatic conclude();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic [31:0] exp, input logic xerr);
        logic [31:0] q;
        logic e;
        logic h;
        u_host.xfer(wr, a, d, q, e, h);
        if (h !== 1'b0) begin
            failures++;
            conclude();
        end
        cmp({31'h0, e}, {31'h0, xerr});
        if (!wr) begin
            cmp(q & m, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, m, exp, 1'b0);
    endtask

    task automatic en(input logic [1:0] exp);
        @(negedge clk_i);
        cmp({30'h0, buck_en}, {30'h0, exp});
        @(posedge clk_i);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        rd(`DBD_ADDR_CTRL3, 32'hffff_ffff, `DBD_CTRL3_RST);
        bus(1'b0, 8'h00, 32'h0, 32'h0, 32'h0, 1'b1);
        din <= 1'b1;
        cyc(`DBD_DIN_FT_CYC - 20);
        en(2'b00);
        cyc(40);
        en(2'b01);
        din <= 1'b0;
        cyc(3);
        en(2'b00);
    endtask

    task automatic t_map();
        dbd_src_t s;
        wr(`DBD_ADDR_MODE, 32'h1);
        wr(`DBD_ADDR_CTRL1, 32'h0);
        din <= 1'b1;
        cyc(`DBD_DIN_FT_CYC + 20);
        for (int i = 0; i < 4; i++) begin
            s = dbd_src_t'(i);
            wr(`DBD_ADDR_CTRL3, {16'h0, s, DBD_SRC_ON, 12'h0});
            cyc(2);
            en({1'b1, s == DBD_SRC_ON || s == DBD_SRC_DIN});
        end
        vs_uv <= 1'b1;
        cyc(3);
        en(2'b00);
        vs_uv <= 1'b0;
        din <= 1'b0;
    endtask

    task automatic t_pwm();
        logic [31:0] on;
        on = 32'h0;
        wr(`DBD_ADDR_CTRL1, 32'd512 << `DBD_DUTY1_LSB);
        wr(`DBD_ADDR_CTRL3, 32'h0000_4000);
        cyc(2100);
        repeat (2048) begin
            @(negedge clk_i);
            on = on + buck_en[0];
        end
        cmp(on, 32'd1024);
        @(posedge clk_i);
        dim_run <= 1'b0;
        cyc(40);
        cmp({31'h0, fallback_en}, 32'h1);
        dim_run <= 1'b1;
        cyc(10);
        cmp({31'h0, fallback_en}, 32'h1);
        rd(S2, 32'h0000_0001, 32'h1);
        cyc(3);
        cmp({31'h0, fallback_en}, 32'h0);
    endtask

    task automatic t_ovt();
        wr(`DBD_ADDR_CTRL3, 32'h0000_8000);
        hot <= 2'b01;
        cool <= 2'b00;
        cyc(3);
        en(2'b00);
        hot <= 2'b00;
        rd(S1, 32'h0800_0020, 32'h0800_0020);
        en(2'b00);
        cool <= 2'b11;
        rd(S1, 32'h0800_0020, 32'h0800_0020);
        rd(S1, 32'h0800_0020, 32'h0);
        cyc(3);
        en(2'b01);
    endtask

    task automatic t_warn();
        tw <= 4'b0110;
        cyc(3);
        rd(S1, 32'h0200_0018, 32'h0200_0010);
        rd(S2, 32'h0260_0000, 32'h0220_0000);
        en(2'b01);
        tw <= 4'h0;
        cyc(3);
        rd(S1, 32'h0200_0018, 32'h0);
    endtask

    task automatic t_max();
        atmax <= 2'b01;
        cend <= 2'b01;
        @(posedge clk_i);
        cend <= 2'b00;
        en(2'b01);
        cend <= 2'b01;
        @(posedge clk_i);
        cend <= 2'b00;
        atmax <= 2'b00;
        cyc(2);
        en(2'b00);
        cyc(TOFF + 4);
        en(2'b01);
        rd(S2, 32'h0008_0000, 32'h0008_0000);
        rd(S2, 32'h0008_0000, 32'h0);
    endtask

    // One switching cycle on channel 1: e marks an early peak, l a long on-time.
    task automatic sw(input logic e, input logic l);
        early <= {1'b0, e};
        tlong <= {1'b0, l};
        cend <= 2'b01;
        @(posedge clk_i);
        cend <= 2'b00;
        @(posedge clk_i);
    endtask

    task automatic t_fault();
        stup <= 2'b01;
        repeat (2) sw(1'b1, 1'b0);
        stup <= 2'b00;
        en(2'b01);
        sw(1'b1, 1'b0);
        repeat (3) sw(1'b0, 1'b1);
        sw(1'b1, 1'b0);
        en(2'b01);
        sw(1'b0, 1'b1);
        sw(1'b1, 1'b0);
        en(2'b00);
        rd(S1, 32'h0800_0002, 32'h0800_0002);
        rd(S1, 32'h0800_0002, 32'h0);
        en(2'b01);
        vlow <= 2'b01;
        repeat (2) sw(1'b1, 1'b0);
        en(2'b00);
        vlow <= 2'b00;
        rd(S1, 32'h0800_0040, 32'h0800_0040);
        rd(S1, 32'h0800_0040, 32'h0);
        wr(`DBD_ADDR_MODE, 32'h0);
        hot <= 2'b01;
        cool <= 2'b00;
        repeat (2) sw(1'b1, 1'b0);
        hot <= 2'b00;
        cool <= 2'b11;
        rd(S1, 32'h0800_0022, 32'h0800_0022);
        rd(S1, 32'h0800_0022, 32'h0800_0022);
        cyc(50);
        rd(S1, 32'h0800_0022, 32'h0);
    endtask

    initial begin
        cyc(3);
        rstn_i <= 1'b1;
        cyc(1);
        t_reset();
        t_map();
        t_pwm();
        t_ovt();
        t_warn();
        t_max();
        t_fault();
        conclude();
    end
endmodule

`default_nettype wire
